// *** design/sbl_cfg.svh ***
// Purpose: constants for the serial boot loader
// Assumes: 20 MHz sys_clk
// Notes: offsets, data width, erased value and timing counts
`ifndef SBL_CFG_SVH
`define SBL_CFG_SVH
`define SBL_CLK_HZ 20000000
`define SBL_BAUD 9600
`define SBL_BIT_CYC (`SBL_CLK_HZ / `SBL_BAUD)
`define SBL_DATA_BITS 8
`define SBL_RAM_BASE 8'h90
`define SBL_RAM_EXEC 8'h91
`define SBL_ERASED 8'hFF
`define SBL_STEP_MS 10
`define SBL_STEP_CYC ((`SBL_CLK_HZ / 1000) * `SBL_STEP_MS)
`endif

// *** design/sbl_loader.sv ***
// Purpose: serial boot loader, RAM image load and nonvolatile byte programming
// Assumes: 8N1 serial link on pins, memories outside reached by strobes
// Notes: one clock, synchronous reset
`timescale 1ns/1ns
`include "sbl_cfg.svh"
module sbl_loader #(
  parameter int STEP_CYC = `SBL_STEP_CYC,
  parameter int BIT_CYC = `SBL_BIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic boot_strap,
  input wire logic nv_mode,
  input wire logic secure_bit,
  input wire logic self_test,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic ram_we,
  output logic [7:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic exec_go,
  output logic [15:0] exec_addr,
  output logic nv_erase,
  output logic nv_prog,
  output logic nv_erase_all,
  output logic [15:0] nv_addr,
  output logic [7:0] nv_wdata,
  input wire logic [7:0] nv_rdata
);
  localparam int BITC = BIT_CYC;
  localparam int HALFC = BITC / 2;

  ////////////////////////////////////////////////////////////////////
  // receive pin synchroniser: change counts when stages two and three agree
  logic [2:0] rx_sync;
  logic rx_lvl;
  wire rx_agree = (rx_sync[1] == rx_sync[2]);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_sync <= 3'h7;
      rx_lvl <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], rx_pin};
      if (rx_agree) rx_lvl <= rx_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // strap and test pins, same three-flop filter; no reset, so the level seen
  // on the first cycle after reset is the one that stood during reset
  wire [3:0] pin_raw = {self_test, secure_bit, nv_mode, boot_strap};
  wire [3:0] pin_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      logic [2:0] pin_sync;
      logic lvl;
      always_ff @(posedge sys_clk) begin
        pin_sync <= {pin_sync[1:0], pin_raw[gi]};
        if (pin_sync[1] == pin_sync[2]) lvl <= pin_sync[2];
      end
      assign pin_lvl[gi] = lvl;
    end
  endgenerate
  wire strap_on = pin_lvl[0];
  wire nv_on = pin_lvl[1];
  wire lock_on = pin_lvl[2];
  wire test_on = pin_lvl[3];

  ////////////////////////////////////////////////////////////////////
  // receiver, 8 data bits sampled mid-bit
  // bit timing
  logic [15:0] rx_cnt;
  logic [3:0] rx_bit;
  logic rx_busy;
  logic [7:0] rx_shift;
  logic rx_done;
  wire rx_tick = rx_busy && (rx_cnt == 16'h0000);
  wire rx_start = !rx_busy && !rx_lvl;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_busy <= 1'b0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (rx_start) begin
        rx_busy <= 1'b1;
        rx_bit <= 4'h0;
        rx_cnt <= 16'(HALFC);
      end else if (rx_busy) begin
        rx_cnt <= rx_tick ? 16'(BITC - 1) : rx_cnt - 16'h0001;
        if (rx_tick) begin
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == 4'h0 && rx_lvl) rx_busy <= 1'b0; // false start
          else if (rx_bit >= 4'h1 && rx_bit <= 4'(`SBL_DATA_BITS))
            rx_shift <= {rx_lvl, rx_shift[7:1]};
          else if (rx_bit == 4'(`SBL_DATA_BITS + 1)) begin
            rx_busy <= 1'b0;
            rx_done <= rx_lvl; // framing error drops the byte
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmitter, start, 8 data, stop
  logic [15:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [9:0] tx_frame;
  logic tx_busy;
  logic tx_load;
  logic [7:0] tx_byte;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_cnt <= 16'h0000;
      tx_bit <= 4'h0;
      tx_frame <= 10'h3FF;
      tx_busy <= 1'b0;
      tx_pin <= 1'b1;
    end else if (tx_load && !tx_busy) begin
      tx_frame <= {1'b1, tx_byte, 1'b0};
      tx_busy <= 1'b1;
      tx_bit <= 4'h0;
      tx_cnt <= 16'(BITC - 1);
      tx_pin <= 1'b0;
    end else if (tx_busy) begin
      if (tx_cnt == 16'h0000) begin
        tx_cnt <= 16'(BITC - 1);
        tx_bit <= tx_bit + 4'h1;
        if (tx_bit == 4'(`SBL_DATA_BITS + 1)) begin
          tx_busy <= 1'b0;
          tx_pin <= 1'b1;
        end else begin
          tx_pin <= tx_frame[tx_bit + 4'h1];
        end
      end else begin
        tx_cnt <= tx_cnt - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control sequencer
  sbl_pkg::sbl_state_type state, next_state;
  logic [7:0] count;
  logic [15:0] addr;
  logic [7:0] data;
  logic [31:0] tmr;
  logic started;
  wire tmr_match = (tmr == 32'h0000_0000);
  wire step_end = tmr_match;

  always_comb begin
    next_state = state;
    unique case (state)
      sbl_pkg::SBL_IDLE:
        if (test_on) next_state = sbl_pkg::SBL_IDLE;
        else if (!started && strap_on)
          next_state = lock_on ? sbl_pkg::SBL_LOCK :
                       (nv_on ? sbl_pkg::SBL_NSKP : sbl_pkg::SBL_RCNT);
      sbl_pkg::SBL_RCNT: if (rx_done) next_state = sbl_pkg::SBL_RDAT;
      sbl_pkg::SBL_RDAT: if (count == 8'h00) next_state = sbl_pkg::SBL_EXEC;
      sbl_pkg::SBL_EXEC: next_state = sbl_pkg::SBL_EXEC;
      sbl_pkg::SBL_NSKP: if (rx_done) next_state = sbl_pkg::SBL_ECHO;
      sbl_pkg::SBL_ECHO: if (!tx_busy) next_state = sbl_pkg::SBL_NAHI;
      sbl_pkg::SBL_NAHI: if (rx_done) next_state = sbl_pkg::SBL_NALO;
      sbl_pkg::SBL_NALO: if (rx_done) next_state = sbl_pkg::SBL_NDAT;
      sbl_pkg::SBL_NDAT: if (rx_done) next_state = sbl_pkg::SBL_ERAS;
      sbl_pkg::SBL_ERAS:
        if (step_end)
          next_state = (data == `SBL_ERASED) ? sbl_pkg::SBL_ECHO : sbl_pkg::SBL_PROG;
      sbl_pkg::SBL_PROG: if (step_end) next_state = sbl_pkg::SBL_ECHO;
      sbl_pkg::SBL_LOCK: next_state = sbl_pkg::SBL_LOCK;
      default: next_state = sbl_pkg::SBL_IDLE;
    endcase
  end

  wire entering_step = (state == sbl_pkg::SBL_NDAT && rx_done) ||
                       (state == sbl_pkg::SBL_ERAS && step_end && data != `SBL_ERASED);
  assign tx_load = (state == sbl_pkg::SBL_ECHO) && !tx_busy;
  assign tx_byte = nv_rdata;

  // sequencer registers and memory strobes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= sbl_pkg::SBL_IDLE;
      started <= 1'b0;
      count <= 8'h00;
      addr <= 16'h0000;
      data <= 8'h00;
      tmr <= 32'h0000_0000;
      ram_we <= 1'b0;
      ram_addr <= `SBL_RAM_BASE;
      ram_wdata <= 8'h00;
      exec_go <= 1'b0;
      exec_addr <= 16'h0000;
      nv_erase <= 1'b0;
      nv_prog <= 1'b0;
      nv_erase_all <= 1'b0;
      nv_addr <= 16'h0000;
      nv_wdata <= 8'h00;
    end else begin
      state <= next_state;
      ram_we <= 1'b0;
      nv_erase_all <= test_on;
      // the strap counts only on the first cycle after reset
      if (state == sbl_pkg::SBL_IDLE) started <= 1'b1;
      if (state == sbl_pkg::SBL_RCNT && rx_done) begin
        count <= rx_shift - 8'h01;
        ram_we <= 1'b1;
        ram_addr <= `SBL_RAM_BASE;
        ram_wdata <= rx_shift;
      end
      if (state == sbl_pkg::SBL_RDAT && rx_done && count != 8'h00) begin
        count <= count - 8'h01;
        ram_we <= 1'b1;
        ram_addr <= ram_addr + 8'h01;
        ram_wdata <= rx_shift;
      end
      if (next_state == sbl_pkg::SBL_EXEC) begin
        exec_go <= 1'b1;
        exec_addr <= {8'h00, `SBL_RAM_EXEC};
      end
      if (state == sbl_pkg::SBL_NAHI && rx_done) addr[15:8] <= rx_shift;
      if (state == sbl_pkg::SBL_NALO && rx_done) addr[7:0] <= rx_shift;
      if (state == sbl_pkg::SBL_NDAT && rx_done) data <= rx_shift;
      if (state == sbl_pkg::SBL_NALO && rx_done) nv_addr <= {addr[15:8], rx_shift};
      if (entering_step) tmr <= 32'(STEP_CYC - 1);
      else if (!tmr_match) tmr <= tmr - 32'h0000_0001;
      nv_erase <= (next_state == sbl_pkg::SBL_ERAS);
      nv_prog <= (next_state == sbl_pkg::SBL_PROG);
      nv_wdata <= data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  chk_count_store: assert property (@(posedge sys_clk) disable iff (rst)
    (state == sbl_pkg::SBL_RCNT && rx_done) |=> (ram_we && ram_addr == 8'h90))
    else $error("count byte not stored at 90h");
  chk_exec_addr: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(exec_go) |-> exec_addr == 16'h0091)
    else $error("execution not at 91h");
  chk_lock_hold: assert property (@(posedge sys_clk) disable iff (rst)
    state == sbl_pkg::SBL_LOCK |-> !ram_we && !exec_go)
    else $error("locked loader wrote ram");
  chk_erase_first: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(nv_prog) |-> $past(nv_erase))
    else $error("program without erase");
  chk_ff_skip: assert property (@(posedge sys_clk) disable iff (rst)
    (state == sbl_pkg::SBL_ERAS && step_end && data == 8'hFF) |=> !nv_prog)
    else $error("programmed erased value");
  chk_count_down: assert property (@(posedge sys_clk) disable iff (rst)
    (state == sbl_pkg::SBL_RDAT && rx_done && count != 8'h00) |=>
    count == $past(count) - 8'h01)
    else $error("count not decremented");
  chk_skip_first: assert property (@(posedge sys_clk) disable iff (rst)
    (state == sbl_pkg::SBL_NSKP && rx_done) |=> state == sbl_pkg::SBL_ECHO)
    else $error("first character not dropped");
  chk_step_time: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(nv_erase) |-> tmr == 32'(STEP_CYC - 1))
    else $error("step timer not loaded");
endmodule

// *** design/sbl_pkg.sv ***
// Purpose: types for the serial boot loader
// Assumes: nothing
// Notes: states use gray codes along the main path
package sbl_pkg;
  typedef enum logic [3:0] {
    SBL_IDLE = 4'h0,
    SBL_RCNT = 4'h1,
    SBL_RDAT = 4'h3,
    SBL_EXEC = 4'h2,
    SBL_NSKP = 4'h6,
    SBL_NAHI = 4'h7,
    SBL_NALO = 4'h5,
    SBL_NDAT = 4'h4,
    SBL_ERAS = 4'hC,
    SBL_PROG = 4'hD,
    SBL_ECHO = 4'hF,
    SBL_LOCK = 4'hE
  } sbl_state_type;
endpackage

// *** tb/sbl_host_model.sv ***
// Purpose: host side of the serial link, sends and receives 8N1 frames
// Assumes: bit time in sys_clk cycles matches the loader
// Notes: line idles at mark (high) between frames, driven only by this model
`timescale 1ns/1ns
module sbl_host_model #(
  parameter int BIT_CYC = 2083
) (
  input wire logic sys_clk,
  input wire logic tx_line,
  output logic rx_line
);
  ////////////////////////////////////////////////////////////////////////////
  initial rx_line = 1'b1;
  // raw binary frames
  // the idle lead-in plus the short tail give a full stop bit, and the tail
  // returns early so a prompt echo is not missed
  task automatic send_byte(input logic [7:0] b);
    int i;
    repeat (BIT_CYC / 2) @(negedge sys_clk);
    rx_line = 1'b0;
    repeat (BIT_CYC) @(negedge sys_clk);
    for (i = 0; i < 8; i++) begin
      rx_line = b[i];
      repeat (BIT_CYC) @(negedge sys_clk);
    end
    rx_line = 1'b1;
    repeat (BIT_CYC / 2 + 16) @(negedge sys_clk);
  endtask
  // bounded wait for a start bit, then mid-bit sampling
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int i;
    int n;
    n = 0;
    b = 8'h00;
    while (tx_line !== 1'b0 && n < 40000) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(negedge sys_clk);
    ok = (tx_line === 1'b0);
    for (i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(negedge sys_clk);
      b[i] = tx_line;
    end
    repeat (BIT_CYC) @(negedge sys_clk);
    ok = ok && (tx_line === 1'b1);
  endtask
endmodule

// *** tb/sbl_loader_tb_top.sv ***
// Purpose: self-checking bench for the serial boot loader
// Assumes: short bit time and short erase and program steps
// Notes: a one-cell array model answers every nonvolatile address
`timescale 1ns/1ns
module sbl_loader_tb_top;
  localparam int STEP = 50;
  localparam int BIT = 208; // shortened bit time keeps the run brief
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic boot_strap = 1'b0;
  logic nv_mode = 1'b0;
  logic secure_bit = 1'b0;
  logic self_test = 1'b0;
  logic rx_pin;
  logic tx_pin, ram_we, exec_go, nv_erase, nv_prog, nv_erase_all;
  logic [7:0] ram_addr, ram_wdata, nv_wdata, nv_rdata;
  logic [15:0] exec_addr, nv_addr, first_we;
  logic [7:0] ram_mem [256];
  logic [7:0] mem_byte = 8'hA7;
  logic got_first = 1'b0;
  logic ord_bad = 1'b0;
  int er_cyc = 0;
  int pr_cyc = 0;
  int fails = 0;
  int cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #25 sys_clk = ~sys_clk;
  assign nv_rdata = mem_byte;
  sbl_loader #(.STEP_CYC(STEP), .BIT_CYC(BIT)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .boot_strap(boot_strap),
    .nv_mode(nv_mode), .secure_bit(secure_bit), .self_test(self_test), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .exec_go(exec_go), .exec_addr(exec_addr), .nv_erase(nv_erase), .nv_prog(nv_prog),
    .nv_erase_all(nv_erase_all), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata));
  sbl_host_model #(.BIT_CYC(BIT)) host_u (.sys_clk(sys_clk), .tx_line(tx_pin), .rx_line(rx_pin));
  // memory models and step counters; erase leaves the cell blank
  always @(posedge sys_clk) begin
    if (ram_we) ram_mem[ram_addr] <= ram_wdata;
    if (ram_we && !got_first) begin
      first_we <= {ram_addr, ram_wdata};
      got_first <= 1'b1;
    end
    if (nv_erase) begin
      er_cyc <= er_cyc + 1;
      mem_byte <= 8'hFF;
    end
    if (nv_prog) begin
      pr_cyc <= pr_cyc + 1;
      mem_byte <= nv_wdata;
      if (er_cyc == 0) ord_bad <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // mode pins are sampled once per reset, so each test starts with one
  task automatic do_reset(input logic strap, input logic nv, input logic sec);
    @(negedge sys_clk);
    rst = 1'b1;
    boot_strap = strap;
    nv_mode = nv;
    secure_bit = sec;
    self_test = 1'b0;
    er_cyc = 0;
    pr_cyc = 0;
    ord_bad = 1'b0;
    got_first = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
  endtask
  task automatic t_ram;
    int n;
    do_reset(1'b1, 1'b0, 1'b0);
    host_u.send_byte(8'h02);
    host_u.send_byte(8'hA5);
    n = 0;
    while (exec_go !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    chk("first ram write", 16'h9002, first_we);
    chk("image byte", 16'h00A5, {8'h00, ram_mem[8'h91]});
    chk("exec go", 16'h0001, {15'h0000, exec_go});
    chk("exec addr", 16'h0091, exec_addr);
    $display("test ram load done");
  endtask
  task automatic t_nv;
    logic [7:0] b;
    logic ok;
    int n;
    do_reset(1'b1, 1'b1, 1'b0);
    host_u.send_byte(8'h00);
    host_u.recv_byte(b, ok);
    chk("first echo", 16'h01A7, {7'h00, ok, b});
    host_u.send_byte(8'h12);
    host_u.send_byte(8'h34);
    host_u.send_byte(8'h55);
    n = 0;
    while ((pr_cyc < STEP || nv_prog !== 1'b0) && n < 500) begin
      @(negedge sys_clk);
      n++;
    end
    chk("nv addr", 16'h1234, nv_addr);
    chk("erase cycles", 16'(STEP), 16'(er_cyc));
    chk("program cycles", 16'(STEP), 16'(pr_cyc));
    chk("erase first", 16'h0000, {15'h0000, ord_bad});
    host_u.recv_byte(b, ok);
    chk("second echo", 16'h0155, {7'h00, ok, b});
    er_cyc = 0;
    host_u.send_byte(8'h00);
    host_u.send_byte(8'h40);
    host_u.send_byte(8'hFF);
    repeat (2 * STEP + 20) @(negedge sys_clk);
    chk("next triple addr", 16'h0040, nv_addr);
    chk("blank erase", 16'(STEP), 16'(er_cyc));
    chk("blank no program", 16'(STEP), 16'(pr_cyc));
    $display("test nonvolatile load done");
  endtask
  task automatic t_lock;
    // a strap raised only after reset must not start the loader
    do_reset(1'b0, 1'b0, 1'b0);
    boot_strap = 1'b1;
    host_u.send_byte(8'h01);
    chk("late strap", 16'h0000, {14'h0000, exec_go, got_first});
    do_reset(1'b1, 1'b0, 1'b1);
    host_u.send_byte(8'h01);
    repeat (20) @(negedge sys_clk);
    chk("locked exec", 16'h0000, {15'h0000, exec_go});
    chk("locked writes", 16'h0000, {15'h0000, got_first});
    chk("array erase idle", 16'h0000, {15'h0000, nv_erase_all});
    self_test = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk("array erase", 16'h0001, {15'h0000, nv_erase_all});
    $display("test lock and self test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // tests run in sequence, then the verdict
  initial begin
    t_ram();
    t_nv();
    t_lock();
    test_done();
  end
  // about thirteen frames of 2100 cycles and a few steps, twice over as margin
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    $display("mismatch watchdog expected finish seen hang");
    test_done();
  end
endmodule
